// ==== hw/din_cond_pkg.sv ====
// Package: register map, layouts and reset values of the input conditioning stage
package din_cond_pkg;

   // ------------------------------------------------------------
   // Sizes
   // ------------------------------------------------------------
   localparam int          NUM_INPUTS   = 32;
   localparam int          SEL_W        = 8;
   localparam logic [7:0]  ENTRY_COUNT  = 8'h08;
   localparam logic [7:0]  ROUTE_COUNT  = 8'h20;

   // ------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam logic [5:0]  IDX_ENTRY_COUNT   = 6'h00;
   localparam logic [5:0]  IDX_SPECIAL_FN    = 6'h01;
   localparam logic [5:0]  IDX_INVERSION     = 6'h02;
   localparam logic [5:0]  IDX_FORCE_ENABLE  = 6'h03;
   localparam logic [5:0]  IDX_FORCE_VALUE   = 6'h04;
   localparam logic [5:0]  IDX_RAW_LEVEL     = 6'h05;
   localparam logic [5:0]  IDX_THRESHOLD     = 6'h06;
   localparam logic [5:0]  IDX_DIFFERENTIAL  = 6'h07;
   localparam logic [5:0]  IDX_ROUTING_EN    = 6'h08;
   localparam logic [5:0]  IDX_STATUS_WORD   = 6'h09;
   localparam logic [5:0]  IDX_ROUTE_COUNT   = 6'h0f;
   localparam logic [5:0]  IDX_ROUTE_BASE    = 6'h10;
   localparam logic [5:0]  IDX_ROUTE_LAST    = 6'h2f;

   // ------------------------------------------------------------
   // Special function bit positions
   // ------------------------------------------------------------
   localparam int          SF_NEG_LIMIT = 0;
   localparam int          SF_POS_LIMIT = 1;
   localparam int          SF_HOME      = 2;
   localparam int          SF_INTERLOCK = 3;
   localparam int          SF_ACTIVE_W  = 16;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [31:0] RST_WORD     = 32'h0000_0000;
   localparam logic [7:0]  RST_SEL      = 8'h00;
   localparam logic [31:0] ERR_WORD     = 32'h0000_0000;

   // ------------------------------------------------------------
   // Carriers
   // ------------------------------------------------------------
   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_s;

   typedef struct packed
   {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } apb_rsp_s;

   typedef struct packed
   {
      logic neg_limit;
      logic pos_limit;
      logic home;
      logic interlock;
   } special_fn_s;

   typedef logic [NUM_INPUTS-1:0][SEL_W-1:0] route_table_t;

   typedef struct packed
   {
      logic [31:0]  special_function_enable;
      logic [31:0]  input_inversion;
      logic [31:0]  force_enable_mask;
      logic [31:0]  forced_input_value;
      logic [31:0]  threshold_select;
      logic [31:0]  differential_mode_select;
      logic [31:0]  routing_enable;
      route_table_t route_sel;
   } cfg_s;

endpackage

// ==== hw/input_bit_cond.sv ====
// Per-input conditioning: inversion and software forcing
`timescale 1ns/1ps
module input_bit_cond
(
   input  wire logic [31:0] raw,
   input  wire logic [31:0] invert,
   input  wire logic [31:0] force_en,
   input  wire logic [31:0] force_val,
   input  wire logic [31:0] clk_dir_use,
   output logic      [31:0] processed
);

   // ------------------------------------------------------------
   // Per bit
   // ------------------------------------------------------------
   genvar i;
   generate
      for (i = 0; i < 32; i++)
      begin : g_bit
         // Bit i is input i+1
         always_comb
         begin
            if (force_en[i])
               processed[i] = force_val[i];
            else if (clk_dir_use[i])
               processed[i] = raw[i];
            else
               processed[i] = raw[i] ^ invert[i];
         end
      end
   endgenerate

endmodule

// ==== hw/digital_input_conditioning.sv ====
// Digital input conditioning stage with APB register access
// How it works
// - Special function enable bit 0 disables, 1 enables that input's function.
// - Special function enable bits 16 to 31 do nothing.
// - Bit 0 negative limit, 1 positive limit, 2 home, 3 interlock.
// - Inversion 0 passes high as 1; inversion 1 turns high into 0.
// - Inversion hits normal and special inputs, not step-clock or direction inputs.
// - Inversion bit n controls input n+1.
// - Force enable set replaces the pin level by software value.
// - Forced inputs present the matching force value bit.
// - Raw value shows unmodified pin levels.
// - Range bit 0 selects 5 V threshold, 1 selects 24 V.
// - Differential bit 0 single-ended, 1 differential, only where supported.
// - Routing enable 1 makes status word come from routing table.
// - Thirty-two readable, writable 8-bit source selectors for the status word.
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/1ps
module digital_input_conditioning
#(
   parameter logic [31:0] THRESHOLD_CAPABLE    = 32'hffff_ffff,
   parameter logic [31:0] DIFFERENTIAL_CAPABLE = 32'hffff_ffff
)
(
   input  wire logic                        clk,
   input  wire logic                        reset,
   input  wire din_cond_pkg::apb_req_s      apb_req,
   output din_cond_pkg::apb_rsp_s           apb_rsp,
   input  wire logic [31:0]                 pin_level,
   input  wire logic [31:0]                 clk_dir_use,
   output logic      [31:0]                 input_status_word,
   output din_cond_pkg::special_fn_s        special_fn,
   output logic      [31:0]                 threshold_24v,
   output logic      [31:0]                 differential_en
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed
   {
      din_cond_pkg::cfg_s        cfg;
      logic [31:0]               raw_level;
      logic [31:0]               status;
      din_cond_pkg::special_fn_s sfn;
      logic [31:0]               thr;
      logic [31:0]               diff;
      logic [31:0]               prdata;
   } state_s;

   state_s      state_ff;
   state_s      nxt_state;
   logic [31:0] processed;
   logic [31:0] routed;
   logic [31:0] rd_word;
   logic [5:0]  idx;
   logic        wr_acc;
   logic        rd_setup;
   logic        mapped;
   logic [4:0]  route_idx;

   // ------------------------------------------------------------
   // Conditioning
   // ------------------------------------------------------------
   input_bit_cond input_bit_cond_i
   (
      .raw       (pin_level),
      .invert    (state_ff.cfg.input_inversion),
      .force_en  (state_ff.cfg.force_enable_mask),
      .force_val (state_ff.cfg.forced_input_value),
      .clk_dir_use (clk_dir_use),
      .processed (processed)
   );

   // ------------------------------------------------------------
   // Routing
   // ------------------------------------------------------------
   genvar r;
   generate
      for (r = 0; r < din_cond_pkg::NUM_INPUTS; r++)
      begin : g_route
         // Source value n selects processed input n; 0 or out of range gives 0
         always_comb
         begin
            if (state_ff.cfg.route_sel[r] != din_cond_pkg::RST_SEL &&
                state_ff.cfg.route_sel[r] <= din_cond_pkg::ROUTE_COUNT)
               routed[r] = processed[5'(state_ff.cfg.route_sel[r] - 8'h01)];
            else
               routed[r] = 1'b0;
         end
      end
   endgenerate

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   assign idx       = apb_req.paddr[7:2];
   assign wr_acc    = apb_req.psel & apb_req.penable & apb_req.pwrite;
   assign rd_setup  = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;
   assign route_idx = 5'(idx - din_cond_pkg::IDX_ROUTE_BASE);

   always_comb
   begin
      mapped  = 1'b1;
      rd_word = din_cond_pkg::ERR_WORD;
      if (idx >= din_cond_pkg::IDX_ROUTE_BASE && idx <= din_cond_pkg::IDX_ROUTE_LAST)
         rd_word = {24'h000000, state_ff.cfg.route_sel[route_idx]};
      else
      begin
         unique case (idx)
            din_cond_pkg::IDX_ENTRY_COUNT:
               rd_word = {24'h000000, din_cond_pkg::ENTRY_COUNT};
            din_cond_pkg::IDX_SPECIAL_FN:
               rd_word = state_ff.cfg.special_function_enable;
            din_cond_pkg::IDX_INVERSION:
               rd_word = state_ff.cfg.input_inversion;
            din_cond_pkg::IDX_FORCE_ENABLE:
               rd_word = state_ff.cfg.force_enable_mask;
            din_cond_pkg::IDX_FORCE_VALUE:
               rd_word = state_ff.cfg.forced_input_value;
            din_cond_pkg::IDX_RAW_LEVEL:
               rd_word = state_ff.raw_level;
            din_cond_pkg::IDX_THRESHOLD:
               rd_word = state_ff.cfg.threshold_select;
            din_cond_pkg::IDX_DIFFERENTIAL:
               rd_word = state_ff.cfg.differential_mode_select;
            din_cond_pkg::IDX_ROUTING_EN:
               rd_word = state_ff.cfg.routing_enable;
            din_cond_pkg::IDX_STATUS_WORD:
               rd_word = state_ff.status;
            din_cond_pkg::IDX_ROUTE_COUNT:
               rd_word = {24'h000000, din_cond_pkg::ROUTE_COUNT};
            default:
               mapped = 1'b0;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      nxt_state = state_ff;
      // Raw value ignores inversion and forcing
      nxt_state.raw_level = pin_level;
      if (state_ff.cfg.routing_enable[0])
         nxt_state.status = routed;
      else
         nxt_state.status = processed;
      // Only the low four enable bits carry functions; 16..31 never looked at
      nxt_state.sfn.neg_limit = state_ff.cfg.special_function_enable[din_cond_pkg::SF_NEG_LIMIT]
                                & processed[din_cond_pkg::SF_NEG_LIMIT];
      nxt_state.sfn.pos_limit = state_ff.cfg.special_function_enable[din_cond_pkg::SF_POS_LIMIT]
                                & processed[din_cond_pkg::SF_POS_LIMIT];
      nxt_state.sfn.home      = state_ff.cfg.special_function_enable[din_cond_pkg::SF_HOME]
                                & processed[din_cond_pkg::SF_HOME];
      nxt_state.sfn.interlock = state_ff.cfg.special_function_enable[din_cond_pkg::SF_INTERLOCK]
                                & processed[din_cond_pkg::SF_INTERLOCK];
      nxt_state.thr  = state_ff.cfg.threshold_select & THRESHOLD_CAPABLE;
      nxt_state.diff = state_ff.cfg.differential_mode_select
                       & DIFFERENTIAL_CAPABLE;
      // Read data captured in setup, shown from a flop in access
      if (rd_setup)
         nxt_state.prdata = rd_word;
      else
         nxt_state.prdata = din_cond_pkg::ERR_WORD;
      if (wr_acc)
      begin
         if (idx >= din_cond_pkg::IDX_ROUTE_BASE && idx <= din_cond_pkg::IDX_ROUTE_LAST)
            nxt_state.cfg.route_sel[route_idx] = apb_req.pwdata[7:0];
         else
         begin
            unique case (idx)
               din_cond_pkg::IDX_SPECIAL_FN:
                  nxt_state.cfg.special_function_enable = apb_req.pwdata;
               din_cond_pkg::IDX_INVERSION:
                  nxt_state.cfg.input_inversion = apb_req.pwdata;
               din_cond_pkg::IDX_FORCE_ENABLE:
                  nxt_state.cfg.force_enable_mask = apb_req.pwdata;
               din_cond_pkg::IDX_FORCE_VALUE:
                  nxt_state.cfg.forced_input_value = apb_req.pwdata;
               din_cond_pkg::IDX_THRESHOLD:
                  nxt_state.cfg.threshold_select = apb_req.pwdata;
               din_cond_pkg::IDX_DIFFERENTIAL:
                  nxt_state.cfg.differential_mode_select = apb_req.pwdata;
               din_cond_pkg::IDX_ROUTING_EN:
                  nxt_state.cfg.routing_enable = apb_req.pwdata;
               default:
                  nxt_state.cfg = state_ff.cfg;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         state_ff.cfg.special_function_enable  <= din_cond_pkg::RST_WORD;
         state_ff.cfg.input_inversion          <= din_cond_pkg::RST_WORD;
         state_ff.cfg.force_enable_mask        <= din_cond_pkg::RST_WORD;
         state_ff.cfg.forced_input_value       <= din_cond_pkg::RST_WORD;
         state_ff.cfg.threshold_select         <= din_cond_pkg::RST_WORD;
         state_ff.cfg.differential_mode_select <= din_cond_pkg::RST_WORD;
         state_ff.cfg.routing_enable           <= din_cond_pkg::RST_WORD;
         state_ff.cfg.route_sel                <= '0;
         state_ff.raw_level                    <= din_cond_pkg::RST_WORD;
         state_ff.status                       <= din_cond_pkg::RST_WORD;
         state_ff.sfn                          <= '0;
         state_ff.thr                          <= din_cond_pkg::RST_WORD;
         state_ff.diff                         <= din_cond_pkg::RST_WORD;
         state_ff.prdata                       <= din_cond_pkg::RST_WORD;
      end
      else
         state_ff <= nxt_state;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_comb
   begin
      apb_rsp.pready  = apb_req.psel & ~apb_req.penable ? 1'b0 : 1'b1;
      apb_rsp.pslverr = apb_req.psel & apb_req.penable & ~mapped;
      apb_rsp.prdata  = state_ff.prdata;
   end

   assign input_status_word = state_ff.status;
   assign special_fn        = state_ff.sfn;
   assign threshold_24v     = state_ff.thr;
   assign differential_en   = state_ff.diff;

endmodule

// ==== tb/din_cond_asserts.sv ====
// Checker: assertions on the input conditioning stage ports
`timescale 1ns/1ps
module din_cond_asserts
#(
   parameter logic [31:0] THRESHOLD_CAPABLE    = 32'hffff_ffff,
   parameter logic [31:0] DIFFERENTIAL_CAPABLE = 32'hffff_ffff
)
(
   input wire logic                      clk,
   input wire logic                      reset,
   input wire din_cond_pkg::apb_req_s    apb_req,
   input wire din_cond_pkg::apb_rsp_s    apb_rsp,
   input wire logic [31:0]               pin_level,
   input wire logic [31:0]               clk_dir_use,
   input wire logic [31:0]               input_status_word,
   input wire din_cond_pkg::special_fn_s special_fn,
   input wire logic [31:0]               threshold_24v,
   input wire logic [31:0]               differential_en
);
   // ------------------------------------------------------------
   // Shadow of written configuration
   // ------------------------------------------------------------
   logic [31:0] sh_ff [9];
   logic [31:0] proc;
   logic [5:0]  idx;
   logic        acc;
   logic        bad;
   assign idx  = apb_req.paddr[7:2];
   assign acc  = apb_req.psel & apb_req.penable;
   assign bad  = (idx inside {[6'h0a:6'h0e], [6'h30:6'h3f]});
   assign proc = (sh_ff[3] & sh_ff[4]) | (~sh_ff[3] & (pin_level ^ (sh_ff[2] & ~clk_dir_use)));
   always_ff @(posedge clk)
      if (reset)
         sh_ff <= '{default: '0};
      else if (acc && apb_req.pwrite && apb_rsp.pready && idx < 6'h09)
         sh_ff[idx] <= apb_req.pwdata;
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   a_zero_wait: assert property (acc |-> apb_rsp.pready)
      else $error("pready low in access");
   a_unmapped_err: assert property (acc && bad |-> apb_rsp.pslverr && apb_rsp.prdata == '0)
      else $error("unmapped access not refused");
   a_mapped_ok: assert property (acc && !bad |-> !apb_rsp.pslverr)
      else $error("mapped access refused");
   a_cfg_readback: assert property (acc && !apb_req.pwrite && idx inside {[1:4], [6:7]}
      |-> apb_rsp.prdata == sh_ff[idx]) else $error("config readback");
   a_raw_level: assert property (acc && !apb_req.pwrite && idx == 6'h05
      |-> apb_rsp.prdata == $past(pin_level, 2)) else $error("raw level");
   a_status_proc: assert property (
      !reset && !sh_ff[8][0] |=> input_status_word == $past(proc))
      else $error("status word");
   a_special_fn: assert property (!reset |=> special_fn ==
      $past({sh_ff[1][0] & proc[0], sh_ff[1][1] & proc[1], sh_ff[1][2] & proc[2],
      sh_ff[1][3] & proc[3]})) else $error("special function");
   a_range_sel: assert property (!reset |=>
      threshold_24v == $past(sh_ff[6] & THRESHOLD_CAPABLE)) else $error("threshold");
   a_diff_sel: assert property (!reset |=>
      differential_en == $past(sh_ff[7] & DIFFERENTIAL_CAPABLE)) else $error("differential");
endmodule
bind digital_input_conditioning din_cond_asserts #(.THRESHOLD_CAPABLE(THRESHOLD_CAPABLE),
   .DIFFERENTIAL_CAPABLE(DIFFERENTIAL_CAPABLE)) din_cond_asserts_i (.clk(clk), .reset(reset),
   .apb_req(apb_req), .apb_rsp(apb_rsp), .pin_level(pin_level), .clk_dir_use(clk_dir_use),
   .input_status_word(input_status_word), .special_fn(special_fn),
   .threshold_24v(threshold_24v), .differential_en(differential_en));

// ==== tb/switch_bank.sv ====
// Partner: switches and sensors driving the input pins
`timescale 1ns/1ps
module switch_bank
(
   input  wire logic        clk,
   input  wire logic [31:0] setting,
   output logic      [31:0] pin_level
);
   // ------------------------------------------------------------
   // Contacts settle on the clock
   // ------------------------------------------------------------
   always_ff @(posedge clk)
      pin_level <= setting;
endmodule

// ==== tb/digital_input_conditioning_test.sv ====
// Testbench: scenarios for the digital input conditioning stage
`timescale 1ns/1ps
module digital_input_conditioning_test;
   // ------------------------------------------------------------
   // Clock, stimulus, instances and shared tasks
   // ------------------------------------------------------------
   localparam logic [31:0] THR_CAP = 32'h0000_ffff;
   localparam logic [31:0] DIF_CAP = 32'h0000_00ff;
   logic                      clk = 1'b0;
   logic                      reset = 1'b1;
   din_cond_pkg::apb_req_s    apb_req = '0;
   din_cond_pkg::apb_rsp_s    apb_rsp;
   din_cond_pkg::special_fn_s special_fn;
   logic [31:0]               pins = '0, cd = '0, inv = '0, fen = '0, fval = '0, p, q;
   logic [31:0]               pin_level, input_status_word, threshold_24v, differential_en;
   logic                      e;
   int                        n_errors = 0, total_checks = 0;
   always #12.5 clk = ~clk;
   switch_bank switch_bank_i (.clk(clk), .setting(pins), .pin_level(pin_level));
   digital_input_conditioning #(.THRESHOLD_CAPABLE(THR_CAP), .DIFFERENTIAL_CAPABLE(DIF_CAP))
   digital_input_conditioning_i (.clk(clk), .reset(reset), .apb_req(apb_req),
      .apb_rsp(apb_rsp), .pin_level(pin_level), .clk_dir_use(cd),
      .input_status_word(input_status_word), .special_fn(special_fn),
      .threshold_24v(threshold_24v), .differential_en(differential_en));
   function automatic logic [31:0] model(input logic [31:0] pv, iv, fe, fv, c);
      return (fe & fv) | (~fe & (pv ^ (iv & ~c)));
   endfunction
   task automatic check(input logic [31:0] g, input logic [31:0] x);
      total_checks++;
      if (g !== x)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, g, x);
      end
   endtask
   task automatic apb(input logic w, input logic [5:0] i, input logic [31:0] d);
      @(posedge clk);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: {i, 2'b00}, pwdata: d};
      @(posedge clk);
      apb_req.penable <= 1'b1;
      @(posedge clk);
      while (apb_rsp.pready !== 1'b1)
         @(posedge clk);
      q = apb_rsp.prdata;
      e = apb_rsp.pslverr;
      apb_req <= '0;
   endtask
   task automatic wr(input logic [5:0] i, input logic [31:0] d);
      apb(1'b1, i, d);
   endtask
   task automatic rd(input logic [5:0] i, input logic [31:0] x, input logic xe);
      apb(1'b0, i, '0);
      check(q, x);
      check({31'h0, e}, {31'h0, xe});
   endtask
   task automatic drive(input logic [31:0] pv, input logic [31:0] c);
      @(posedge clk);
      pins <= pv;
      cd <= c;
   endtask
   task automatic settle();
      repeat (3) @(posedge clk);
      @(negedge clk);
      p = model(pins, inv, fen, fval, cd);
   endtask
   task automatic chk_status();
      settle();
      check(input_status_word, p);
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      rd(6'h00, 32'h0000_0008, 1'b0);
      for (int k = 1; k < 10; k++)
         rd(k[5:0], 32'h0, 1'b0);
      rd(6'h0f, 32'h0000_0020, 1'b0);
      rd(6'h2f, 32'h0, 1'b0);
   endtask
   task automatic t_invert();
      drive(32'h0000_00a5, 32'h0000_0001);
      inv = 32'h8000_000f;
      wr(6'h02, inv);
      chk_status();
      rd(6'h05, 32'h0000_00a5, 1'b0);
   endtask
   task automatic t_force();
      fen = 32'h0000_0103;
      fval = 32'h0000_0102;
      wr(6'h03, fen);
      wr(6'h04, fval);
      chk_status();
      drive(32'h0000_005a, 32'h0000_0001);
      chk_status();
      rd(6'h05, 32'h0000_005a, 1'b0);
   endtask
   task automatic t_special();
      wr(6'h01, 32'hffff_000f);
      settle();
      check({28'h0, special_fn}, {28'h0, p[0], p[1], p[2], p[3]});
      wr(6'h01, 32'hffff_0005);
      settle();
      check({28'h0, special_fn}, {28'h0, p[0], 1'b0, p[2], 1'b0});
   endtask
   task automatic t_range();
      logic [31:0] v;
      for (int k = 0; k < 3; k++)
      begin
         v = (k == 0) ? 32'hffff_ffff : (k == 1) ? 32'h5a5a_0f01 : 32'h0;
         wr(6'h06, v);
         wr(6'h07, v);
         settle();
         check(threshold_24v, v & THR_CAP);
         check(differential_en, v & DIF_CAP);
         rd(6'h07, v, 1'b0);
      end
   endtask
   task automatic t_route();
      wr(6'h10, 32'hffff_ff03);
      rd(6'h10, 32'h0000_0003, 1'b0);
      wr(6'h11, 32'h0000_0001);
      wr(6'h12, 32'h0000_0021);
      wr(6'h08, 32'h0000_0001);
      settle();
      check(input_status_word, {29'h0, 1'b0, p[0], p[2]});
      wr(6'h08, 32'h0);
      chk_status();
   endtask
   task automatic t_refuse();
      rd(6'h0a, 32'h0, 1'b1);
      wr(6'h30, 32'hffff_ffff);
      rd(6'h30, 32'h0, 1'b1);
      wr(6'h00, 32'h0000_00ff);
      rd(6'h00, 32'h0000_0008, 1'b0);
   endtask
   task automatic t_rerst();
      @(posedge clk);
      reset <= 1'b1;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      inv = '0;
      fen = '0;
      fval = '0;
      for (int k = 1; k < 9; k++)
         if (k != 5)
            rd(k[5:0], 32'h0, 1'b0);
      rd(6'h10, 32'h0, 1'b0);
      chk_status();
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_invert();
      t_force();
      t_special();
      t_range();
      t_route();
      t_refuse();
      t_rerst();
      final_report();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      n_errors++;
      final_report();
   end
endmodule
